// >>> common/mem_copy_irq_cfg.svh
// Register map and field constants of the memory copy interrupt block
`ifndef MEM_COPY_IRQ_CFG_SVH
`define MEM_COPY_IRQ_CFG_SVH

`define ADDR_WIDTH           32
`define OFS_IRQ_ENABLE_SET   32'h40028008
`define OFS_IRQ_ENABLE_CLEAR 32'h4002800C
`define OFS_IRQ_ENABLE_STATE 32'h40028010
`define OFS_TRANSFER_STATUS  32'h40028014
`define BIT_END_OF_TRANSFER  0
`define BIT_BUFFER_FULL      1
`define EVENT_COUNT          2
`define ENABLE_RESET         2'h0

`endif

// >>> common/mem_copy_irq_pkg.sv
// Types shared by the memory copy interrupt block
package mem_copy_irq_pkg;
    typedef logic [1:0]  event_vec_type;
    typedef logic [31:0] word_type;
endpackage

// >>> hdl/mem_copy_irq_regs.sv
// Interrupt enable, mask and status registers of the memory copy helper
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "mem_copy_irq_cfg.svh"

module mem_copy_irq_regs #(
    parameter int EVENT_COUNT = `EVENT_COUNT,
    parameter int ADDR_WIDTH  = `ADDR_WIDTH,
    parameter int DATA_WIDTH  = 32
) (
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [31:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        END_OF_TRANSFER_IN,
    input  wire logic        BUFFER_FULL_IN,
    output logic             IRQ_OUT,
    output logic             COPY_DONE_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // Status inputs come from the DMA channel logic, same clock: no sync
    mem_copy_irq_pkg::event_vec_type enable;
    mem_copy_irq_pkg::event_vec_type status;
    mem_copy_irq_pkg::event_vec_type next_enable;
    mem_copy_irq_pkg::word_type      next_rdata;
    logic                            wr_en;
    logic                            rd_en;
    logic                            hit_set;
    logic                            hit_clear;
    logic                            hit_state;
    logic                            hit_status;
    logic                            hit_any;
    logic                            setup_read;
    mem_copy_irq_pkg::event_vec_type set_bits;
    mem_copy_irq_pkg::event_vec_type clear_bits;

    ////////////////////////////////////////////////////////////////////////
    // Decode, ports and word type are built for two events in one 32-bit word
    if (EVENT_COUNT != 2 || ADDR_WIDTH != 32 || DATA_WIDTH != 32) begin : bad_params
        $error("only two events in one 32-bit word are supported");
    end

    // One comparator shape for every register, so all decode the full byte address
    function automatic logic addr_match(input logic [31:0] addr, input logic [31:0] ofs);
        addr_match = (addr == ofs);
    endfunction

    assign status = {BUFFER_FULL_IN, END_OF_TRANSFER_IN};

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign wr_en      = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign rd_en      = PSEL_IN && PENABLE_IN && !PWRITE_IN;
    assign setup_read = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
    assign hit_set    = addr_match(PADDR_IN, `OFS_IRQ_ENABLE_SET);
    assign hit_clear  = addr_match(PADDR_IN, `OFS_IRQ_ENABLE_CLEAR);
    assign hit_state  = addr_match(PADDR_IN, `OFS_IRQ_ENABLE_STATE);
    assign hit_status = addr_match(PADDR_IN, `OFS_TRANSFER_STATUS);
    assign hit_any    = hit_set || hit_clear || hit_state || hit_status;

    // Zero bits give all-zero masks, so a written 0 leaves the enable alone
    assign set_bits    = (wr_en && hit_set) ? PWDATA_IN[1:0] : 2'h0;
    assign clear_bits  = (wr_en && hit_clear) ? PWDATA_IN[1:0] : 2'h0;
    // Set applied after clear; APB carries one address so both never meet
    assign next_enable = (enable & ~clear_bits) | set_bits;

    // Write-only registers read as zero; upper bits always zero
    assign next_rdata = hit_state  ? {30'h0, enable} :
                        hit_status ? {30'h0, status} :
                        32'h0;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            enable     <= `ENABLE_RESET;
            PRDATA_OUT <= 32'h0;
        end else begin
            enable     <= next_enable;
            PRDATA_OUT <= (PSEL_IN && !PENABLE_IN && !PWRITE_IN) ? next_rdata : 32'h0;
        end
    end

    // Zero wait states: read data is captured in the setup cycle
    assign PREADY_OUT    = 1'b1;
    // Unmapped addresses are flagged so software sees a bad pointer
    assign PSLVERR_OUT   = PSEL_IN && PENABLE_IN && !hit_any;
    assign IRQ_OUT       = |(status & enable);
    assign COPY_DONE_OUT = |status;

    ////////////////////////////////////////////////////////////////////////
    set_enables_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && hit_set) |=> ((enable & $past(PWDATA_IN[1:0])) == $past(PWDATA_IN[1:0])))
        else $error("enable set write lost");
    clear_enables_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && hit_clear) |=> ((enable & $past(PWDATA_IN[1:0])) == 2'h0))
        else $error("enable clear write lost");
    hold_enables_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !(wr_en && (hit_set || hit_clear)) |=> $stable(enable))
        else $error("enable changed without write");
    mask_read_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (PSEL_IN && !PENABLE_IN && !PWRITE_IN && hit_state)
        |=> (PRDATA_OUT == {30'h0, $past(enable)}))
        else $error("mask readback wrong");
    status_read_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (PSEL_IN && !PENABLE_IN && !PWRITE_IN && hit_status)
        |=> (PRDATA_OUT == {30'h0, $past(BUFFER_FULL_IN), $past(END_OF_TRANSFER_IN)}))
        else $error("status readback wrong");
    upper_zero_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        PRDATA_OUT[31:2] == 30'h0)
        else $error("reserved bits not zero");
    irq_level_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        IRQ_OUT == ((END_OF_TRANSFER_IN && enable[0]) || (BUFFER_FULL_IN && enable[1])))
        else $error("interrupt level wrong");
    copy_done_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        COPY_DONE_OUT == (END_OF_TRANSFER_IN || BUFFER_FULL_IN))
        else $error("copy done wrong");

    ////////////////////////////////////////////////////////////////////////
    // Reset state
    reset_clears_a: assert property (@(posedge CLK_IN)
        !NRST_IN
        |=> (enable == 2'h0) && (PRDATA_OUT == 32'h0))
        else $error("reset state wrong");

    ////////////////////////////////////////////////////////////////////////
    // Per-bit set and clear
    set_eot_bit_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && hit_set && PWDATA_IN[0])
        |=> enable[0])
        else $error("end of transfer enable not set");

    set_full_bit_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && hit_set && PWDATA_IN[1])
        |=> enable[1])
        else $error("buffer full enable not set");

    clear_eot_bit_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && hit_clear && PWDATA_IN[0])
        |=> !enable[0])
        else $error("end of transfer enable not cleared");

    clear_full_bit_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && hit_clear && PWDATA_IN[1])
        |=> !enable[1])
        else $error("buffer full enable not cleared");

    // Zeros in a set or clear word must not touch the other enable
    set_zero_keep_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && hit_set)
        |=> ((enable & ~$past(PWDATA_IN[1:0])) == ($past(enable) & ~$past(PWDATA_IN[1:0]))))
        else $error("set write disturbed other enable");

    clear_zero_keep_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && hit_clear)
        |=> ((enable | $past(PWDATA_IN[1:0])) == ($past(enable) | $past(PWDATA_IN[1:0]))))
        else $error("clear write disturbed other enable");

    read_no_effect_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        rd_en
        |=> $stable(enable))
        else $error("read changed enables");

    unmapped_write_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (wr_en && !hit_any)
        |=> $stable(enable))
        else $error("unmapped write changed enables");

    ////////////////////////////////////////////////////////////////////////
    // Read data
    mask_eot_read_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (setup_read && hit_state)
        |=> (PRDATA_OUT[0] == $past(enable[0])))
        else $error("end of transfer mask bit wrong");

    status_eot_read_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (setup_read && hit_status)
        |=> (PRDATA_OUT[0] == $past(END_OF_TRANSFER_IN)))
        else $error("end of transfer status bit wrong");

    status_full_read_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (setup_read && hit_status)
        |=> (PRDATA_OUT[1] == $past(BUFFER_FULL_IN)))
        else $error("buffer full status bit wrong");

    write_only_read_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (setup_read && (hit_set || hit_clear))
        |=> (PRDATA_OUT == 32'h0))
        else $error("write-only register read not zero");

    unmapped_read_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (setup_read && !hit_any)
        |=> (PRDATA_OUT == 32'h0))
        else $error("unmapped read not zero");

    rdata_idle_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !setup_read
        |=> (PRDATA_OUT == 32'h0))
        else $error("read data outside a read");

    ////////////////////////////////////////////////////////////////////////
    // Bus response
    ready_high_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        PREADY_OUT)
        else $error("ready low");

    slverr_unmapped_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (PSEL_IN && PENABLE_IN && !hit_any)
        |-> PSLVERR_OUT)
        else $error("unmapped access not flagged");

    slverr_mapped_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (PSEL_IN && PENABLE_IN && hit_any)
        |-> !PSLVERR_OUT)
        else $error("mapped access flagged");

    slverr_idle_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !(PSEL_IN && PENABLE_IN)
        |-> !PSLVERR_OUT)
        else $error("error outside access phase");

    ////////////////////////////////////////////////////////////////////////
    // Interrupt and completion levels
    irq_needs_enable_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (enable == 2'h0)
        |-> !IRQ_OUT)
        else $error("interrupt without enable");

    irq_needs_status_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !(END_OF_TRANSFER_IN || BUFFER_FULL_IN)
        |-> !IRQ_OUT)
        else $error("interrupt without status");

    irq_eot_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (END_OF_TRANSFER_IN && enable[0])
        |-> IRQ_OUT)
        else $error("end of transfer interrupt missing");

    irq_full_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (BUFFER_FULL_IN && enable[1])
        |-> IRQ_OUT)
        else $error("buffer full interrupt missing");

    done_eot_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        END_OF_TRANSFER_IN
        |-> COPY_DONE_OUT)
        else $error("copy done missing on end of transfer");

    done_full_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        BUFFER_FULL_IN
        |-> COPY_DONE_OUT)
        else $error("copy done missing on buffer full");

    done_idle_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !(END_OF_TRANSFER_IN || BUFFER_FULL_IN)
        |-> !COPY_DONE_OUT)
        else $error("copy done without status");

endmodule

// >>> tb/dma_rx_model.sv
// Receive channel status levels seen by the interrupt block
`timescale 1ns/10ps
module dma_rx_model (
    input  wire logic       clk_in,
    input  wire logic [1:0] level_in,
    output logic            end_of_transfer_out,
    output logic            buffer_full_out
);
    // Registered so that levels change only just after an edge, like the channel
    always_ff @(posedge clk_in) begin
        end_of_transfer_out <= level_in[0];
        buffer_full_out     <= level_in[1];
    end
endmodule

// >>> tb/mem_copy_irq_regs_test.sv
// Bench for the memory copy interrupt registers
`timescale 1ns/10ps
`include "mem_copy_irq_cfg.svh"
module mem_copy_irq_regs_test;
    logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0;
    logic        pready, pslverr, irq, done, eot, full, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
    logic [1:0]  lvl = 2'h0;
    logic [31:0] ta[6] = '{`OFS_IRQ_ENABLE_SET, `OFS_IRQ_ENABLE_SET, `OFS_IRQ_ENABLE_SET,
                           `OFS_IRQ_ENABLE_CLEAR, `OFS_IRQ_ENABLE_CLEAR, `OFS_IRQ_ENABLE_CLEAR};
    logic [1:0]  td[6] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h2};
    logic [1:0]  te[6] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h2, 2'h0};
    int          mismatches = 0, samples_checked = 0;
    initial forever #10 clk = ~clk;
    mem_copy_irq_regs mem_copy_irq_regs_inst (.CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .END_OF_TRANSFER_IN(eot), .BUFFER_FULL_IN(full), .IRQ_OUT(irq), .COPY_DONE_OUT(done));
    dma_rx_model dma_rx_model_inst (.clk_in(clk), .level_in(lvl),
        .end_of_transfer_out(eot), .buffer_full_out(full));
    // Idle cycle after each transfer keeps psel from being driven twice in one step
    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk) pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata; err = pslverr; psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, `OFS_IRQ_ENABLE_STATE, 32'h0, r);
        chk("mask after reset", 32'h0, r);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ta[i], {30'h0, td[i]}, r);
            apb(1'b0, `OFS_IRQ_ENABLE_STATE, 32'h0, r);
            chk("mask", {30'h0, te[i]}, r);
        end
        $display("enable test done");
        apb(1'b1, `OFS_IRQ_ENABLE_SET, 32'h1, r);
        for (int s = 0; s < 4; s++) begin
            lvl <= s[1:0];
            repeat (2) @(posedge clk);
            apb(1'b0, `OFS_TRANSFER_STATUS, 32'h0, r);
            chk("status", s, r);
            chk("irq", {31'h0, s[0]}, {31'h0, irq});
            chk("copy done", {31'h0, |s[1:0]}, {31'h0, done});
        end
        apb(1'b1, `OFS_IRQ_ENABLE_SET, 32'h2, r);
        lvl <= 2'h2;
        repeat (2) @(posedge clk);
        chk("irq full", 32'h1, {31'h0, irq});
        $display("status test done");
        apb(1'b0, 32'h40028018, 32'h0, r);
        chk("unmapped read", 32'h0, r);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b0, `OFS_IRQ_ENABLE_SET, 32'h0, r);
        chk("set register read", 32'h0, r);
        chk("mapped error", 32'h0, {31'h0, err});
        $display("decode test done");
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, `OFS_IRQ_ENABLE_STATE, 32'h0, r);
        chk("mask after second reset", 32'h0, r);
        $display("reset test done");
        complete_run;
    end
    // Whole run needs about 90 cycles; a hang is cut well past that
    initial begin
        repeat (1000) @(posedge clk);
        mismatches++;
        complete_run;
    end
endmodule
